// [verilog/axsp_regs.sv]
// Design decisions made here: register access over APB and the address map.
`include "axsp_consts.svh"

module axsp_regs #(
    parameter int ADDR_W = 8
) (
    // Clock and reset.
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // APB slave.
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [ADDR_W-1:0]    paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Motion core, same clock.
    input  wire logic                 start_cmd,
    input  wire logic                 stop_cmd,
    input  wire logic                 pulse_issued,
    input  wire logic [13:0]          core_speed,
    input  wire logic [13:0]          operating_speed,
    input  wire logic [13:0]          initial_speed,
    input  wire logic [23:0]          auto_slowdown_value,
    input  wire logic [3:0]           zphase_count_setting,
    // Pins from outside the clock domain.
    input  wire logic                 slowdown_pin,
    input  wire logic                 inposition_pin,
    input  wire logic                 encoder_pin,
    input  wire logic                 zphase_pin,
    // Results to the motion core.
    output axsp_pkg::axsp_cfg_type    axis_cfg,
    output logic                      axis_running,
    output logic                      decel_start,
    output logic                      slowdown_stop_req,
    output logic                      op_done,
    output logic                      slowdown_pin_state,
    output logic                      inposition_state
);

    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    if (ADDR_W < 7) begin : g_addr_check
        $error("ADDR_W must be at least 7 to reach every register.");
    end

    axsp_pkg::axsp_state_type st_ff;
    axsp_pkg::axsp_state_type nxt_st;

    logic        setup_phase;
    logic        wr_access;
    logic [7:0]  addr8;
    logic        stopped;
    logic        positioning;
    logic        interp;
    logic        method_manual;
    logic [23:0] sd_point;
    logic [31:0] sd_word;
    logic [31:0] speed_word;
    logic        enc_event;
    logic        z_event;
    logic        count_event;
    logic        feed_write;
    logic [13:0] half_span;

    assign addr8       = 8'(paddr);
    assign setup_phase = psel && !penable;
    assign wr_access   = psel && penable && pwrite;
    assign stopped     = (st_ff.axis == axsp_pkg::AXSP_STOPPED);
    assign method_manual = st_ff.mode[`AXSP_BIT_SD_METHOD];

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            `AXSP_OFS_SD_SET, `AXSP_OFS_ACC_S, `AXSP_OFS_DEC_S, `AXSP_OFS_CUR_SPEED,
            `AXSP_OFS_SD_READ, `AXSP_OFS_FEED, `AXSP_OFS_MAIN_FEED, `AXSP_OFS_REMAIN,
            `AXSP_OFS_MODE, `AXSP_OFS_PRE_SD_SET, `AXSP_OFS_PRE_ACC_S, `AXSP_OFS_PRE_DEC_S,
            `AXSP_OFS_PRE_FEED, `AXSP_OFS_PRE_MAIN, `AXSP_OFS_PRE_MODE: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    function automatic logic is_positioning(input logic [6:0] m);
        case (m)
            `AXSP_MOD_INC, `AXSP_MOD_SW_INC, `AXSP_MOD_LIN_INC: is_positioning = 1'b1;
            default: is_positioning = 1'b0;
        endcase
    endfunction

    function automatic logic is_interp(input logic [6:0] m);
        case (m)
            `AXSP_MOD_LIN_CONT, `AXSP_MOD_LIN_INC: is_interp = 1'b1;
            default: is_interp = 1'b0;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Derived values
    // ----------------------------------------------------------------
    assign positioning = is_positioning(st_ff.mode[6:0]);
    assign interp      = is_interp(st_ff.mode[6:0]);

    // Auto point is the sum of computed value and offset, wrapping in 24 bits.
    assign sd_point = method_manual ? st_ff.sd_set
                                    : 24'(auto_slowdown_value + st_ff.sd_set);

    // Upper byte is zero for the manual method and copies setting bit 23 for auto; written bits 31:24 never land there.
    assign sd_word = method_manual ? {8'h00, st_ff.sd_set}
                                   : {{8{st_ff.sd_set[23]}}, st_ff.sd_set};

    // While stopped the Z-phase counter is reloaded every cycle, so it reads the setting.
    assign speed_word = {12'h000, st_ff.zcnt, 2'b00,
                         (stopped ? 14'h0000 :
                          (st_ff.mode[6:0] == `AXSP_MOD_PULSER) ? operating_speed : core_speed)};

    assign half_span   = 14'((operating_speed - initial_speed) >> 1);
    // A rising edge is accepted when stages two and three agree high over a low level.
    assign enc_event   = !st_ff.enc_lvl && st_ff.enc_sync[1] && st_ff.enc_sync[2];
    assign z_event     = !st_ff.z_lvl && st_ff.z_sync[1] && st_ff.z_sync[2];
    assign count_event = st_ff.mode[`AXSP_BIT_COUNT_SRC] ? enc_event : pulse_issued;
    assign feed_write  = wr_access && (addr8 == `AXSP_OFS_FEED ||
                                       (addr8 == `AXSP_OFS_PRE_FEED && stopped));

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;

        // Pin synchronisers; a change counts once stages two and three agree.
        nxt_st.sd_sync  = {st_ff.sd_sync[1:0], slowdown_pin};
        nxt_st.inp_sync = {st_ff.inp_sync[1:0], inposition_pin};
        nxt_st.z_sync   = {st_ff.z_sync[1:0], zphase_pin};
        nxt_st.enc_sync = {st_ff.enc_sync[1:0], encoder_pin};
        if (st_ff.sd_sync[1] == st_ff.sd_sync[2]) begin
            nxt_st.sd_pin = st_ff.sd_sync[2];
        end
        if (st_ff.inp_sync[1] == st_ff.inp_sync[2]) begin
            nxt_st.inp_pin = st_ff.inp_sync[2];
        end
        if (st_ff.z_sync[1] == st_ff.z_sync[2]) begin
            nxt_st.z_lvl = st_ff.z_sync[2];
        end
        if (st_ff.enc_sync[1] == st_ff.enc_sync[2]) begin
            nxt_st.enc_lvl = st_ff.enc_sync[2];
        end

        // Read data and error are prepared in the setup phase.
        if (setup_phase) begin
            nxt_st.slverr = !is_mapped(addr8);
            case (addr8)
                `AXSP_OFS_SD_SET:     nxt_st.rdata = sd_word;
                `AXSP_OFS_ACC_S:      nxt_st.rdata = {19'h00000, st_ff.acc_s};
                `AXSP_OFS_DEC_S:      nxt_st.rdata = {19'h00000, st_ff.dec_s};
                `AXSP_OFS_CUR_SPEED:  nxt_st.rdata = speed_word;
                `AXSP_OFS_SD_READ:    nxt_st.rdata = {8'h00, sd_point};
                `AXSP_OFS_FEED:       nxt_st.rdata = st_ff.feed;
                `AXSP_OFS_MAIN_FEED:  nxt_st.rdata = st_ff.main_feed;
                `AXSP_OFS_REMAIN:     nxt_st.rdata = st_ff.remain;
                `AXSP_OFS_MODE:       nxt_st.rdata = {18'h00000, st_ff.mode};
                `AXSP_OFS_PRE_SD_SET: nxt_st.rdata = method_manual ? {8'h00, st_ff.pre_sd_set}
                                                   : {{8{st_ff.pre_sd_set[23]}}, st_ff.pre_sd_set};
                `AXSP_OFS_PRE_ACC_S:  nxt_st.rdata = {19'h00000, st_ff.pre_acc_s};
                `AXSP_OFS_PRE_DEC_S:  nxt_st.rdata = {19'h00000, st_ff.pre_dec_s};
                `AXSP_OFS_PRE_FEED:   nxt_st.rdata = st_ff.pre_feed;
                `AXSP_OFS_PRE_MAIN:   nxt_st.rdata = st_ff.pre_main_feed;
                `AXSP_OFS_PRE_MODE:   nxt_st.rdata = {18'h00000, st_ff.pre_mode};
                default:              nxt_st.rdata = `AXSP_RST_WORD;
            endcase
        end

        // Register writes take effect in the access phase.
        if (wr_access) begin
            case (addr8)
                `AXSP_OFS_SD_SET:    nxt_st.sd_set = pwdata[23:0];
                `AXSP_OFS_ACC_S:     nxt_st.acc_s = pwdata[12:0];
                `AXSP_OFS_DEC_S:     nxt_st.dec_s = pwdata[12:0];
                `AXSP_OFS_FEED:      nxt_st.feed = pwdata;
                `AXSP_OFS_MAIN_FEED: nxt_st.main_feed = pwdata;
                `AXSP_OFS_MODE:      nxt_st.mode = pwdata[13:0] & `AXSP_MODE_WMASK;
                `AXSP_OFS_PRE_SD_SET: begin
                    nxt_st.pre_sd_set = pwdata[23:0];
                    if (stopped) begin
                        nxt_st.sd_set = pwdata[23:0];
                    end
                end
                `AXSP_OFS_PRE_ACC_S: begin
                    nxt_st.pre_acc_s = pwdata[12:0];
                    if (stopped) begin
                        nxt_st.acc_s = pwdata[12:0];
                    end
                end
                `AXSP_OFS_PRE_DEC_S: begin
                    nxt_st.pre_dec_s = pwdata[12:0];
                    if (stopped) begin
                        nxt_st.dec_s = pwdata[12:0];
                    end
                end
                `AXSP_OFS_PRE_FEED: begin
                    nxt_st.pre_feed = pwdata;
                    if (stopped) begin
                        nxt_st.feed = pwdata;
                    end
                end
                `AXSP_OFS_PRE_MAIN: begin
                    nxt_st.pre_main_feed = pwdata;
                    if (stopped) begin
                        nxt_st.main_feed = pwdata;
                    end
                end
                `AXSP_OFS_PRE_MODE: begin
                    nxt_st.pre_mode = pwdata[13:0] & `AXSP_MODE_WMASK;
                    if (stopped) begin
                        nxt_st.mode = pwdata[13:0] & `AXSP_MODE_WMASK;
                    end
                end
                // Read-only and unmapped offsets leave every register untouched.
                default: nxt_st.mode = st_ff.mode;
            endcase
        end

        // Axis run state and remaining-pulse counter.
        nxt_st.done = 1'b0;
        case (st_ff.axis)
            axsp_pkg::AXSP_STOPPED: begin
                nxt_st.zcnt = zphase_count_setting;
                if (start_cmd) begin
                    nxt_st.axis   = axsp_pkg::AXSP_RUNNING;
                    nxt_st.remain = st_ff.feed;
                end
            end
            axsp_pkg::AXSP_RUNNING: begin
                if (z_event && st_ff.zcnt != 4'h0) begin
                    nxt_st.zcnt = st_ff.zcnt - 4'h1;
                end
                if (count_event && st_ff.remain != 32'h00000000) begin
                    nxt_st.remain = st_ff.remain - 32'h00000001;
                end
                if (stop_cmd) begin
                    nxt_st.axis = axsp_pkg::AXSP_STOPPED;
                    nxt_st.done = 1'b1;
                end else if (positioning && st_ff.remain == 32'h00000000 &&
                             (!st_ff.mode[`AXSP_BIT_INP_WAIT] || st_ff.inp_pin)) begin
                    nxt_st.axis = axsp_pkg::AXSP_STOPPED;
                    nxt_st.done = 1'b1;
                end
            end
            default: nxt_st.axis = axsp_pkg::AXSP_STOPPED;
        endcase

        // A write of the target feed clears the counter and wins over a load.
        if (feed_write) begin
            nxt_st.remain = `AXSP_RST_WORD;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '{axis: axsp_pkg::AXSP_STOPPED, sd_set: `AXSP_RST_SD_SET,
                       pre_sd_set: `AXSP_RST_SD_SET, acc_s: `AXSP_RST_S_SECTION,
                       pre_acc_s: `AXSP_RST_S_SECTION, dec_s: `AXSP_RST_S_SECTION,
                       pre_dec_s: `AXSP_RST_S_SECTION, feed: `AXSP_RST_WORD,
                       pre_feed: `AXSP_RST_WORD, main_feed: `AXSP_RST_WORD,
                       pre_main_feed: `AXSP_RST_WORD, mode: `AXSP_RST_MODE,
                       pre_mode: `AXSP_RST_MODE, remain: `AXSP_RST_WORD, zcnt: 4'h0,
                       rdata: `AXSP_RST_WORD, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign pready  = 1'b1;
    assign prdata  = st_ff.rdata;
    assign pslverr = st_ff.slverr;

    always_comb begin
        axis_cfg.mode_code              = st_ff.mode[6:0];
        axis_cfg.slowdown_input_enable  = st_ff.mode[`AXSP_BIT_SD_ENABLE];
        axis_cfg.inposition_wait_enable = st_ff.mode[`AXSP_BIT_INP_WAIT];
        axis_cfg.scurve_enable          = st_ff.mode[`AXSP_BIT_SCURVE];
        axis_cfg.count_source_select    = st_ff.mode[`AXSP_BIT_COUNT_SRC];
        axis_cfg.done_timing            = st_ff.mode[`AXSP_BIT_DONE_TIMING];
        axis_cfg.slowdown_method_select = method_manual;
        axis_cfg.accel_section  = (st_ff.acc_s == 13'h0000) ? half_span : {1'b0, st_ff.acc_s};
        axis_cfg.decel_section  = (st_ff.dec_s == 13'h0000) ? half_span : {1'b0, st_ff.dec_s};
        axis_cfg.target_feed    = st_ff.feed;
        axis_cfg.main_axis_feed = interp ? st_ff.main_feed : `AXSP_RST_WORD;
        axis_cfg.interp_active  = interp;
        axis_cfg.positioning_active = positioning;
    end

    assign axis_running       = !stopped;
    assign slowdown_pin_state = st_ff.sd_pin;
    assign inposition_state   = st_ff.inp_pin;
    assign op_done            = st_ff.done;
    // Manual: below the setting; auto: at or below the computed point.
    assign decel_start = !stopped && positioning &&
                         (method_manual ? (st_ff.remain < {8'h00, sd_point})
                                        : (st_ff.remain <= {8'h00, sd_point}));
    assign slowdown_stop_req = !stopped && st_ff.mode[`AXSP_BIT_SD_ENABLE] && st_ff.sd_pin;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_sd_upper_byte: assert property (setup_phase && addr8 == `AXSP_OFS_SD_SET |=>
        prdata[31:24] == (method_manual ? 8'h00 : {8{prdata[23]}}))
        else $error("Slow-down setting upper byte wrong.");
    chk_feed_clears: assert property (wr_access && addr8 == `AXSP_OFS_FEED |=>
        st_ff.remain == 32'h00000000)
        else $error("Feed write did not clear remaining count.");
    chk_start_loads: assert property (stopped && start_cmd && !feed_write |=>
        st_ff.remain == $past(st_ff.feed) && axis_running)
        else $error("Start did not load remaining count.");
    chk_count_down: assert property (!stopped && count_event && st_ff.remain != 0 && !feed_write |=>
        st_ff.remain == $past(st_ff.remain) - 32'h1)
        else $error("Remaining count did not step down.");
    chk_speed_stopped: assert property (stopped |-> speed_word[13:0] == 14'h0000)
        else $error("Speed not zero while stopped.");
    chk_zphase_hold: assert property (stopped |=> st_ff.zcnt == $past(zphase_count_setting))
        else $error("Z-phase count not held while stopped.");
    chk_ro_ignored: assert property (wr_access && addr8 == `AXSP_OFS_SD_READ |=>
        $stable(st_ff.sd_set) && $stable(st_ff.mode))
        else $error("Read-only write changed state.");
    chk_pre_copy: assert property (wr_access && addr8 == `AXSP_OFS_PRE_ACC_S && stopped |=>
        st_ff.acc_s == $past(pwdata[12:0]))
        else $error("Pre-register not copied while stopped.");
    chk_auto_point: assert property (setup_phase && addr8 == `AXSP_OFS_SD_READ && !method_manual |=>
        prdata == {8'h00, 24'($past(auto_slowdown_value) + $past(st_ff.sd_set))})
        else $error("Auto slow-down point wrong.");
    chk_accel_zero: assert property (st_ff.acc_s == 13'h0000 |-> axis_cfg.accel_section == half_span)
        else $error("Zero accel section not substituted.");
    chk_main_feed: assert property (!interp |-> axis_cfg.main_axis_feed == 32'h0)
        else $error("Main feed used outside interpolation.");

    cov_start:  cover property (stopped && start_cmd);
    cov_done:   cover property (op_done && positioning);
    cov_decel:  cover property (!decel_start ##1 decel_start);
    cov_slverr: cover property (psel && penable && pslverr);

endmodule

// [verilog/axsp_consts.svh]
`ifndef AXSP_CONSTS_SVH
`define AXSP_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define AXSP_OFS_SD_SET      8'h00
`define AXSP_OFS_ACC_S       8'h04
`define AXSP_OFS_DEC_S       8'h08
`define AXSP_OFS_CUR_SPEED   8'h0c
`define AXSP_OFS_SD_READ     8'h10
`define AXSP_OFS_FEED        8'h14
`define AXSP_OFS_MAIN_FEED   8'h18
`define AXSP_OFS_REMAIN      8'h1c
`define AXSP_OFS_MODE        8'h20
`define AXSP_OFS_PRE_SD_SET  8'h40
`define AXSP_OFS_PRE_ACC_S   8'h44
`define AXSP_OFS_PRE_DEC_S   8'h48
`define AXSP_OFS_PRE_FEED    8'h54
`define AXSP_OFS_PRE_MAIN    8'h58
`define AXSP_OFS_PRE_MODE    8'h60

// ----------------------------------------------------------------
// Fields, masks and mode codes
// ----------------------------------------------------------------
`define AXSP_MODE_WMASK      14'h3f7f
`define AXSP_BIT_SD_ENABLE   8
`define AXSP_BIT_INP_WAIT    9
`define AXSP_BIT_SCURVE      10
`define AXSP_BIT_COUNT_SRC   11
`define AXSP_BIT_DONE_TIMING 12
`define AXSP_BIT_SD_METHOD   13
`define AXSP_MOD_CONT_POS    7'h00
`define AXSP_MOD_CONT_NEG    7'h08
`define AXSP_MOD_PULSER      7'h01
`define AXSP_MOD_SWITCH      7'h02
`define AXSP_MOD_ORG_POS     7'h10
`define AXSP_MOD_ORG_NEG     7'h18
`define AXSP_MOD_INC         7'h41
`define AXSP_MOD_TIMER       7'h47
`define AXSP_MOD_SW_INC      7'h56
`define AXSP_MOD_LIN_CONT    7'h62
`define AXSP_MOD_LIN_INC     7'h63

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define AXSP_RST_SD_SET      24'h000000
`define AXSP_RST_S_SECTION   13'h0000
`define AXSP_RST_WORD        32'h00000000
`define AXSP_RST_MODE        14'h0000
`endif

// [verilog/axsp_pkg.sv]
package axsp_pkg;

    typedef enum logic [0:0] {
        AXSP_STOPPED = 1'b0,
        AXSP_RUNNING = 1'b1
    } axsp_axis_type;

    typedef struct packed {
        logic [6:0]  mode_code;
        logic        slowdown_input_enable;
        logic        inposition_wait_enable;
        logic        scurve_enable;
        logic        count_source_select;
        logic        done_timing;
        logic        slowdown_method_select;
        logic [13:0] accel_section;
        logic [13:0] decel_section;
        logic [31:0] target_feed;
        logic [31:0] main_axis_feed;
        logic        interp_active;
        logic        positioning_active;
    } axsp_cfg_type;

    typedef struct packed {
        axsp_axis_type axis;
        logic [23:0]   sd_set;
        logic [23:0]   pre_sd_set;
        logic [12:0]   acc_s;
        logic [12:0]   pre_acc_s;
        logic [12:0]   dec_s;
        logic [12:0]   pre_dec_s;
        logic [31:0]   feed;
        logic [31:0]   pre_feed;
        logic [31:0]   main_feed;
        logic [31:0]   pre_main_feed;
        logic [13:0]   mode;
        logic [13:0]   pre_mode;
        logic [31:0]   remain;
        logic [3:0]    zcnt;
        logic [31:0]   rdata;
        logic          slverr;
        logic [2:0]    sd_sync;
        logic [2:0]    inp_sync;
        logic [2:0]    z_sync;
        logic [2:0]    enc_sync;
        logic          sd_pin;
        logic          inp_pin;
        logic          z_lvl;
        logic          enc_lvl;
        logic          done;
    } axsp_state_type;

endpackage

// [tb/axsp_apb_host.sv]
module axsp_apb_host (
    // Clock.
    input  wire logic        pclk,
    // Requests.
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    // Answers.
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Host bus cycles
    // ----------------------------------------------------------------
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // Entered right after a rising edge; an idle cycle follows each transfer.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
endmodule

// [tb/axsp_regs_tb_top.sv]
module axsp_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Signals, host model and design
    // ----------------------------------------------------------------
    logic        pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr, err;
    logic        start_cmd = 1'b0, stop_cmd = 1'b0, pulse_issued = 1'b0;
    logic        sd_pin = 1'b0, inp_pin = 1'b0, enc_pin = 1'b0, z_pin = 1'b0;
    logic        running, done, sd_state, sd_stop, inp_state, dec_go;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [13:0] core_speed = 14'h0123, operating_speed = 14'h0064, initial_speed = 14'h0014;
    logic [23:0] auto_slowdown_value = 24'h000100;
    logic [3:0]  zphase_count_setting = 4'h5;
    axsp_pkg::axsp_cfg_type axis_cfg;
    int          error_cnt = 0, samples_checked = 0;
    always #25 pclk = ~pclk;
    axsp_apb_host host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    axsp_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .start_cmd, .stop_cmd, .pulse_issued, .core_speed, .operating_speed, .initial_speed,
        .auto_slowdown_value, .zphase_count_setting, .slowdown_pin(sd_pin), .inposition_pin(inp_pin),
        .encoder_pin(enc_pin), .zphase_pin(z_pin), .axis_cfg, .axis_running(running), .decel_start(dec_go),
        .slowdown_stop_req(sd_stop), .op_done(done), .slowdown_pin_state(sd_state), .inposition_state(inp_state));
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rd, err);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        host.xfer(1'b0, a, 32'h0, rd, err);
        chk32(rd, exp);
    endtask
    task automatic t_slowdown;
        wr(8'h00, 32'h5aa00001);
        rdc(8'h00, 32'hffa00001);
        wr(8'h00, 32'h80000010);
        host.xfer(1'b0, 8'h10, 32'h0, rd, err);
        chk32({8'h00, rd[23:0]}, 32'h00000110);
        wr(8'h20, 32'h00002000);
        wr(8'h00, 32'h00800000);
        rdc(8'h00, 32'h00800000);
        wr(8'h10, 32'h00000001);
        rdc(8'h10, 32'h00800000);
    endtask
    task automatic t_scurve;
        wr(8'h04, 32'hffffffff);
        rdc(8'h04, 32'h00001fff);
        wr(8'h48, 32'h00001fff);
        rdc(8'h08, 32'h00001fff);
        wr(8'h04, 32'h0);
        wr(8'h08, 32'h0);
        chk32({axis_cfg.accel_section, axis_cfg.decel_section}, {14'd40, 14'd40});
    endtask
    task automatic t_feed;
        wr(8'h20, 32'h00000041);
        wr(8'h14, 32'd100);
        rdc(8'h1c, 32'h0);
        rdc(8'h0c, 32'h00050000);
        start_cmd <= 1'b1;
        @(posedge pclk);
        start_cmd    <= 1'b0;
        pulse_issued <= 1'b1;
        repeat (3) @(posedge pclk);
        pulse_issued <= 1'b0;
        wr(8'h1c, 32'h5);
        rdc(8'h1c, 32'd97);
        wr(8'h14, 32'd200);
        rdc(8'h1c, 32'h0);
        rdc(8'h14, 32'd200);
    endtask
    task automatic t_modes;
        logic [6:0] codes[11] = '{7'h00, 7'h08, 7'h01, 7'h02, 7'h10, 7'h18, 7'h41, 7'h47, 7'h56, 7'h62, 7'h63};
        wr(8'h18, 32'h00001234);
        foreach (codes[i]) begin
            wr(8'h60, {25'h0, codes[i]});
            chk32({25'h0, axis_cfg.mode_code}, {25'h0, codes[i]});
            chk32(axis_cfg.main_axis_feed, codes[i][6:5] == 2'b11 ? 32'h1234 : 32'h0);
        end
        wr(8'h20, 32'hffffffff);
        rdc(8'h20, 32'h00003f7f);
        chk32({axis_cfg.count_source_select, axis_cfg.inposition_wait_enable, axis_cfg.slowdown_input_enable}, 3'h7);
    endtask
    task automatic t_motion;
        host.xfer(1'b0, 8'h30, 32'h0, rd, err);
        chk32({err, rd[30:0]}, 32'h80000000);
        wr(8'h20, 32'h00002b41);
        wr(8'h14, 32'd2);
        wr(8'h00, 32'd5);
        sd_pin <= 1'b1;
        repeat (5) @(posedge pclk);
        start_cmd <= 1'b1;
        @(posedge pclk);
        start_cmd <= 1'b0;
        @(negedge pclk);
        chk32({28'h0, sd_state, sd_stop, dec_go, running}, 32'hf);
        @(posedge pclk);
        repeat (2) begin
            {enc_pin, z_pin} <= 2'b11;
            repeat (5) @(posedge pclk);
            {enc_pin, z_pin} <= 2'b00;
            repeat (5) @(posedge pclk);
        end
        rdc(8'h1c, 32'h0);
        rdc(8'h0c, 32'h00030123);
        @(negedge pclk);
        chk32({31'h0, running}, 32'h1);
        @(posedge pclk);
        inp_pin <= 1'b1;
        repeat (5) @(posedge pclk);
        @(negedge pclk);
        chk32({29'h0, inp_state, done, running}, 32'h6);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge pclk);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_slowdown();
        t_scurve();
        t_feed();
        t_modes();
        t_motion();
        report_and_stop();
    end
endmodule
